//--- logic/usm_top.sv
// usb device state manager: visible states, suspend, requests, apb registers
//
// Function
// RULE1 - nonzero set-configuration alone enters Configured
// RULE2 - config or alt change resets endpoints, DATA0
// RULE3 - idle bus suspends; state is kept
// RULE4 - suspend after 3 ms idle
// RULE5 - suspend allowed from any powered state
// RULE6 - disabled upstream port also suspends
// RULE7 - bus activity leaves suspend
// RULE8 - wakeup enable flag gates wakeup signalling
// RULE9 - bus reset clears wakeup enable
// RULE10 - host waits 100 ms before reset
// RULE11 - reset ends at default, unconfigured, awake
// RULE12 - default address serves control pipe
// RULE13 - accepted address moves Default to Address
// RULE14 - host reads descriptors in fixed order
// RULE15 - configured endpoints take described characteristics
// RULE16 - report and select alternate setting
// RULE17 - alternates numbered from zero, start zero
// RULE18 - endpoint transfer type fixed per alternate
// RULE19 - act on request after setup ack
// RULE20 - finish request before status completes
// RULE21 - port reset 10 ms, change flags end
// RULE22 - new address within 2 ms after status
// RULE23 - bad request answered with stall
// RULE24 - encoded state plus separate suspended flag
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps

module usm_top #(
  parameter int unsigned NUM_IF   = 4,
  parameter int unsigned NUM_EP   = 8,
  parameter int unsigned IDLE_CYC = usm_pkg::SUSP_IDLE_CYC,
  parameter int unsigned PRST_CYC = usm_pkg::PRST_CYC
) (
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [7:0]          paddr_in,
  input  wire logic [31:0]         pwdata_in,
  output logic                     pready_out,
  output logic [31:0]              prdata_out,
  output logic                     pslverr_out,
  input  wire logic                bus_reset_in,
  input  wire logic                bus_activity_in,
  input  wire logic                port_disabled_in,
  input  wire logic                req_valid_in,
  input  wire logic [3:0]          req_kind_in,
  input  wire logic [7:0]          req_value_in,
  input  wire logic [7:0]          req_index_in,
  input  wire logic                status_done_in,
  input  wire logic [NUM_EP-1:0]   toggle_flip_in,
  output logic                     busy_out,
  output logic                     stall_out,
  output logic [7:0]               alt_report_out,
  output logic [1:0]               dev_state_out,
  output logic                     suspended_out,
  output logic [6:0]               dev_addr_out,
  output logic [7:0]               config_out,
  output logic [NUM_IF*8-1:0]      alt_setting_out,
  output logic [NUM_EP-1:0]        ep_toggle_out,
  output logic [NUM_EP-1:0]        ep_halt_out,
  output logic                     rwake_en_out,
  output logic                     wakeup_out,
  output logic                     port_reset_out,
  output logic                     port_enabled_out,
  output logic                     port_change_out
);

  // one counter width covers both the idle timer and the port reset timer
  localparam int unsigned CNT_W = $clog2(IDLE_CYC > PRST_CYC ? IDLE_CYC : PRST_CYC) + 1;
  localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(IDLE_CYC - 1);
  localparam logic [CNT_W-1:0] PRST_LAST = CNT_W'(PRST_CYC - 1);
  localparam logic [7:0] NUM_IF_B = 8'(NUM_IF);
  localparam logic [7:0] NUM_EP_B = 8'(NUM_EP);

  typedef struct packed {
    usm_pkg::usm_state_e   dev_state;
    logic                  suspended;
    logic [6:0]            dev_addr;
    logic [6:0]            new_addr;
    logic                  addr_pend;
    logic [7:0]            cfg_val;
    logic [NUM_IF*8-1:0]   alt;
    logic [NUM_EP-1:0]     toggle;
    logic [NUM_EP-1:0]     halt;
    logic                  rwake_en;
    logic                  busy;
    logic [3:0]            kind;
    logic [7:0]            val;
    logic [7:0]            idx;
    logic                  stall;
    logic [7:0]            alt_rd;
    logic                  wake;
    logic [CNT_W-1:0]      idle_cnt;
    logic [CNT_W-1:0]      prst_cnt;
    logic                  prst_on;
    logic                  port_en;
    logic                  port_chg;
    logic [7:0]            cfg_count;
    logic [7:0]            alt_count;
    logic [2*NUM_EP-1:0]   ifmap;
    logic                  pready;
    logic [31:0]           prdata;
    logic                  pslverr;
    logic [1:0]            pdis_sync;
  } usm_st_s;

  usm_st_s st_r;
  usm_st_s st_nxt;

  // endpoints whose interface number matches, from the software map
  function automatic logic [NUM_EP-1:0] usm_eps_of_if(input logic [2*NUM_EP-1:0] map, input logic [7:0] ifn);
    logic [NUM_EP-1:0] m;
    m = '0;
    for (int e = 0; e < NUM_EP; e++) begin
      m[e] = ({6'h00, map[2*e +: 2]} == ifn);
    end
    return m;
  endfunction

  // unmapped offsets still get pready, together with pslverr and zero data
  function automatic logic usm_mapped(input logic [7:0] a);
    return (a == usm_pkg::OFS_CTRL) || (a == usm_pkg::OFS_CFG) || (a == usm_pkg::OFS_IFMAP) ||
           (a == usm_pkg::OFS_STATUS) || (a == usm_pkg::OFS_PCHG) || (a == usm_pkg::OFS_EPSTAT);
  endfunction

  always_comb begin
    logic              acc;
    logic              wr;
    logic [NUM_EP-1:0] epm;
    logic              pchg_clr;
    logic              prst_go;
    logic              wake_go;
    acc      = psel_in && penable_in && !st_r.pready;
    wr       = psel_in && penable_in && st_r.pready && pwrite_in && usm_mapped(paddr_in);
    epm      = '0;
    pchg_clr = 1'b0;
    prst_go  = 1'b0;
    wake_go  = 1'b0;
    st_nxt   = st_r;

    st_nxt.pdis_sync = {st_r.pdis_sync[0], port_disabled_in};
    st_nxt.wake      = 1'b0;

    // apb slave: one wait cycle, write lands on the edge that samples pready
    st_nxt.pready  = acc;
    st_nxt.pslverr = acc && !usm_mapped(paddr_in);
    st_nxt.prdata  = '0;
    if (acc && !pwrite_in) begin
      case (paddr_in)
        usm_pkg::OFS_CFG: begin
          st_nxt.prdata[usm_pkg::CFG_CNT_LSB +: 8] = st_r.cfg_count;
          st_nxt.prdata[usm_pkg::CFG_ALT_LSB +: 8] = st_r.alt_count;
        end
        usm_pkg::OFS_IFMAP: begin
          st_nxt.prdata[2*NUM_EP-1:0] = st_r.ifmap;
        end
        usm_pkg::OFS_STATUS: begin
          st_nxt.prdata[usm_pkg::ST_STATE_LSB +: 2] = st_r.dev_state;
          st_nxt.prdata[usm_pkg::ST_SUSP_BIT]       = st_r.suspended;
          st_nxt.prdata[usm_pkg::ST_RWAKE_BIT]      = st_r.rwake_en;
          st_nxt.prdata[usm_pkg::ST_PEN_BIT]        = st_r.port_en;
          st_nxt.prdata[usm_pkg::ST_PRST_BIT]       = st_r.prst_on;
          st_nxt.prdata[usm_pkg::ST_ADDR_LSB +: 7]  = st_r.dev_addr;
          st_nxt.prdata[usm_pkg::ST_CFGV_LSB +: 8]  = st_r.cfg_val;
        end
        usm_pkg::OFS_PCHG: begin
          st_nxt.prdata[0] = st_r.port_chg;
        end
        usm_pkg::OFS_EPSTAT: begin
          st_nxt.prdata[NUM_EP-1:0]                      = st_r.toggle;
          st_nxt.prdata[usm_pkg::EP_HALT_LSB +: NUM_EP]  = st_r.halt;
        end
        default: begin
          st_nxt.prdata = '0;
        end
      endcase
    end
    if (wr) begin
      case (paddr_in)
        usm_pkg::OFS_CTRL: begin
          prst_go = pwdata_in[usm_pkg::CTRL_PRST_BIT];
          wake_go = pwdata_in[usm_pkg::CTRL_WAKE_BIT];
        end
        usm_pkg::OFS_CFG: begin
          st_nxt.cfg_count = pwdata_in[usm_pkg::CFG_CNT_LSB +: 8];
          st_nxt.alt_count = pwdata_in[usm_pkg::CFG_ALT_LSB +: 8];
        end
        usm_pkg::OFS_IFMAP: begin
          st_nxt.ifmap = pwdata_in[2*NUM_EP-1:0];
        end
        usm_pkg::OFS_PCHG: begin
          pchg_clr = pwdata_in[0];
        end
        default: begin
          pchg_clr = 1'b0;
        end
      endcase
    end

    // downstream port reset: the write completes at once, the change flag marks the end
    if (pchg_clr) begin
      st_nxt.port_chg = 1'b0; // RULE21
    end
    if (prst_go && !st_r.prst_on) begin
      st_nxt.prst_on  = 1'b1; // RULE21
      st_nxt.port_en  = 1'b0;
      st_nxt.prst_cnt = '0;
    end else if (st_r.prst_on) begin
      if (st_r.prst_cnt == PRST_LAST) begin
        st_nxt.prst_on  = 1'b0; // RULE21
        st_nxt.port_en  = 1'b1;
        st_nxt.port_chg = 1'b1;
      end else begin
        st_nxt.prst_cnt = st_r.prst_cnt + 1'b1;
      end
    end

    // wakeup only while suspended and enabled by the host
    if (wake_go && st_r.suspended && st_r.rwake_en) begin
      st_nxt.wake = 1'b1; // RULE8
    end

    // suspend keeps the encoded state untouched, only the flag changes
    if (bus_activity_in) begin
      st_nxt.idle_cnt  = '0;
      st_nxt.suspended = 1'b0; // RULE7 RULE24
    end else if (st_r.pdis_sync[1]) begin
      st_nxt.suspended = 1'b1; // RULE6
    end else if (st_r.idle_cnt == IDLE_LAST) begin
      st_nxt.suspended = 1'b1; // RULE3 RULE4 RULE5
    end else begin
      st_nxt.idle_cnt = st_r.idle_cnt + 1'b1; // RULE4
    end

    st_nxt.toggle = st_r.toggle ^ toggle_flip_in;

    // requests seen while busy are dropped: the host keeps one at a time
    // latch request at setup ack, act on it the next cycle
    if (req_valid_in && !st_r.busy) begin
      st_nxt.busy  = 1'b1; // RULE19
      st_nxt.stall = 1'b0;
      st_nxt.kind  = req_kind_in;
      st_nxt.val   = req_value_in;
      st_nxt.idx   = req_index_in;
    end else if (st_r.busy) begin
      st_nxt.busy = 1'b0; // RULE20
      case (usm_pkg::usm_req_e'(st_r.kind))
        usm_pkg::USM_REQ_SET_ADDR: begin
          if (st_r.dev_state == usm_pkg::USM_CONFIGURED || st_r.val[7]) begin
            st_nxt.stall = 1'b1; // RULE23
          end else begin
            st_nxt.new_addr  = st_r.val[6:0];
            st_nxt.addr_pend = 1'b1;
          end
        end
        usm_pkg::USM_REQ_SET_CFG: begin
          if (st_r.dev_state == usm_pkg::USM_DEFAULT || st_r.val > st_r.cfg_count) begin
            st_nxt.stall = 1'b1; // RULE23
          end else if (st_r.val == usm_pkg::UNCONFIGURED) begin
            st_nxt.dev_state = usm_pkg::USM_ADDRESS;
            st_nxt.cfg_val   = usm_pkg::UNCONFIGURED;
          end else begin
            st_nxt.dev_state = usm_pkg::USM_CONFIGURED; // RULE1
            st_nxt.cfg_val   = st_r.val; // RULE15
            st_nxt.alt       = '0; // RULE17
            st_nxt.toggle    = '0; // RULE2
            st_nxt.halt      = '0; // RULE2
          end
        end
        usm_pkg::USM_REQ_SET_INTF: begin
          if (st_r.dev_state != usm_pkg::USM_CONFIGURED || st_r.idx >= NUM_IF_B || st_r.val >= st_r.alt_count) begin
            st_nxt.stall = 1'b1; // RULE23 RULE17
          end else begin
            epm = usm_eps_of_if(st_r.ifmap, st_r.idx);
            st_nxt.alt[st_r.idx[$clog2(NUM_IF)-1:0]*8 +: 8] = st_r.val; // RULE16 RULE18
            st_nxt.toggle = st_nxt.toggle & ~epm; // RULE2
            st_nxt.halt   = st_r.halt & ~epm; // RULE2
          end
        end
        usm_pkg::USM_REQ_GET_INTF: begin
          if (st_r.dev_state != usm_pkg::USM_CONFIGURED || st_r.idx >= NUM_IF_B) begin
            st_nxt.stall = 1'b1; // RULE23
          end else begin
            st_nxt.alt_rd = st_r.alt[st_r.idx[$clog2(NUM_IF)-1:0]*8 +: 8]; // RULE16
          end
        end
        usm_pkg::USM_REQ_SET_RWAKE: begin
          st_nxt.rwake_en = 1'b1; // RULE8
        end
        usm_pkg::USM_REQ_CLR_RWAKE: begin
          st_nxt.rwake_en = 1'b0; // RULE8
        end
        usm_pkg::USM_REQ_SET_HALT, usm_pkg::USM_REQ_CLR_HALT: begin
          if (st_r.idx >= NUM_EP_B || (st_r.idx != 8'h00 && st_r.dev_state != usm_pkg::USM_CONFIGURED)) begin
            st_nxt.stall = 1'b1; // RULE23
          end else if (st_r.kind == usm_pkg::USM_REQ_SET_HALT) begin
            st_nxt.halt[st_r.idx[$clog2(NUM_EP)-1:0]] = 1'b1;
          end else begin
            st_nxt.halt[st_r.idx[$clog2(NUM_EP)-1:0]]   = 1'b0;
            st_nxt.toggle[st_r.idx[$clog2(NUM_EP)-1:0]] = 1'b0;
          end
        end
        default: begin
          st_nxt.stall = 1'b1; // RULE23
        end
      endcase
    end

    // new address only after its own status stage
    if (status_done_in && st_r.addr_pend && !st_r.busy) begin
      st_nxt.addr_pend = 1'b0;
      st_nxt.dev_addr  = st_r.new_addr; // RULE22
      st_nxt.dev_state = (st_r.new_addr != usm_pkg::DEFAULT_ADDR) ? usm_pkg::USM_ADDRESS
                                                                   : usm_pkg::USM_DEFAULT; // RULE13
    end

    // usb bus reset returns to default address, unconfigured, awake
    if (bus_reset_in) begin
      st_nxt.dev_state = usm_pkg::USM_DEFAULT; // RULE11
      st_nxt.suspended = 1'b0; // RULE11
      st_nxt.dev_addr  = usm_pkg::DEFAULT_ADDR; // RULE12
      st_nxt.addr_pend = 1'b0;
      st_nxt.cfg_val   = usm_pkg::UNCONFIGURED;
      st_nxt.alt       = '0;
      st_nxt.toggle    = '0;
      st_nxt.halt      = '0;
      st_nxt.rwake_en  = 1'b0; // RULE9
      st_nxt.busy      = 1'b0;
      st_nxt.stall     = 1'b0;
      st_nxt.idle_cnt  = '0;
      st_nxt.wake      = 1'b0;
    end
  end

  // software counts restart at one configuration and one alternate setting
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r           <= '0;
      st_r.dev_state <= usm_pkg::USM_DEFAULT;
      st_r.dev_addr  <= usm_pkg::DEFAULT_ADDR;
      st_r.cfg_val   <= usm_pkg::UNCONFIGURED;
      st_r.cfg_count <= usm_pkg::CFG_COUNT_RST;
      st_r.alt_count <= usm_pkg::ALT_COUNT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready_out       = st_r.pready;
  assign prdata_out       = st_r.prdata;
  assign pslverr_out      = st_r.pslverr;
  assign busy_out         = st_r.busy;
  assign stall_out        = st_r.stall;
  assign alt_report_out   = st_r.alt_rd;
  assign dev_state_out    = st_r.dev_state;
  assign suspended_out    = st_r.suspended;
  assign dev_addr_out     = st_r.dev_addr;
  assign config_out       = st_r.cfg_val;
  assign alt_setting_out  = st_r.alt;
  assign ep_toggle_out    = st_r.toggle;
  assign ep_halt_out      = st_r.halt;
  assign rwake_en_out     = st_r.rwake_en;
  assign wakeup_out       = st_r.wake;
  assign port_reset_out   = st_r.prst_on;
  assign port_enabled_out = st_r.port_en;
  assign port_change_out  = st_r.port_chg;

endmodule

//--- logic/usm_pkg.sv
// constants and types shared by the usb device state manager
package usm_pkg;

  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned SUSP_IDLE_MS    = 3;
  localparam int unsigned PRST_MS         = 10;
  localparam int unsigned SUSP_IDLE_CYC   = SUSP_IDLE_MS * (CLK_HZ / 1000);
  localparam int unsigned PRST_CYC        = PRST_MS * (CLK_HZ / 1000);

  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_CFG         = 8'h04;
  localparam logic [7:0]  OFS_IFMAP       = 8'h08;
  localparam logic [7:0]  OFS_STATUS      = 8'h0c;
  localparam logic [7:0]  OFS_PCHG        = 8'h10;
  localparam logic [7:0]  OFS_EPSTAT      = 8'h14;

  localparam int unsigned CTRL_PRST_BIT   = 0;
  localparam int unsigned CTRL_WAKE_BIT   = 1;
  localparam int unsigned CFG_CNT_LSB     = 0;
  localparam int unsigned CFG_ALT_LSB     = 8;
  localparam int unsigned ST_STATE_LSB    = 0;
  localparam int unsigned ST_SUSP_BIT     = 2;
  localparam int unsigned ST_RWAKE_BIT    = 3;
  localparam int unsigned ST_PEN_BIT      = 4;
  localparam int unsigned ST_PRST_BIT     = 5;
  localparam int unsigned ST_ADDR_LSB     = 8;
  localparam int unsigned ST_CFGV_LSB     = 16;
  localparam int unsigned EP_HALT_LSB     = 16;

  localparam logic [7:0]  CFG_COUNT_RST   = 8'h01;
  localparam logic [7:0]  ALT_COUNT_RST   = 8'h01;
  localparam logic [6:0]  DEFAULT_ADDR    = 7'h00;
  localparam logic [7:0]  UNCONFIGURED    = 8'h00;

  typedef enum logic [1:0] {
    USM_DEFAULT,
    USM_ADDRESS,
    USM_CONFIGURED
  } usm_state_e;

  typedef enum logic [3:0] {
    USM_REQ_SET_ADDR,
    USM_REQ_SET_CFG,
    USM_REQ_SET_INTF,
    USM_REQ_GET_INTF,
    USM_REQ_SET_RWAKE,
    USM_REQ_CLR_RWAKE,
    USM_REQ_SET_HALT,
    USM_REQ_CLR_HALT,
    USM_REQ_OTHER
  } usm_req_e;

endpackage

//--- test/usm_host_model.sv
// host-side model that issues control requests to the state manager
`timescale 1ns/1ps
module usm_host_model (
  input  wire logic       clk_in,
  input  wire logic       busy_in,
  output logic            req_valid_out = 1'b0,
  output logic [3:0]      req_kind_out = 4'h0,
  output logic [7:0]      req_value_out = 8'h00,
  output logic [7:0]      req_index_out = 8'h00,
  output logic            status_done_out = 1'b0,
  output logic            activity_out = 1'b0
);
  // setup, then the status stage once the device is idle; ok low on a hang
  task automatic request(input logic [3:0] kind, input logic [7:0] value, input logic [7:0] index,
                         output logic ok);
    int n;
    n = 0;
    @(posedge clk_in);
    req_valid_out <= 1'b1;
    req_kind_out <= kind;
    req_value_out <= value;
    req_index_out <= index;
    activity_out <= 1'b1;
    @(posedge clk_in);
    req_valid_out <= 1'b0;
    activity_out <= 1'b0;
    // setup fields go stale once the packet has passed
    req_kind_out <= ~kind;
    req_value_out <= ~value;
    req_index_out <= ~index;
    @(negedge clk_in);
    while (busy_in !== 1'b0 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    @(posedge clk_in);
    status_done_out <= 1'b1;
    activity_out <= 1'b1;
    @(posedge clk_in);
    status_done_out <= 1'b0;
    activity_out <= 1'b0;
    ok = (n < 20);
  endtask
endmodule

//--- test/usm_top_assertions.sv
// concurrent checks on the ports of the usb device state manager
`timescale 1ns/1ps
module usm_top_assertions #(
  parameter int unsigned NUM_EP   = 8,
  parameter int unsigned IDLE_CYC = 20
) (
  input wire logic              clk_in,
  input wire logic              rst_in,
  input wire logic              bus_reset_in,
  input wire logic              bus_activity_in,
  input wire logic              port_disabled_in,
  input wire logic              req_valid_in,
  input wire logic [3:0]        req_kind_in,
  input wire logic [7:0]        req_value_in,
  input wire logic              busy_out,
  input wire logic [1:0]        dev_state_out,
  input wire logic              suspended_out,
  input wire logic [6:0]        dev_addr_out,
  input wire logic [7:0]        config_out,
  input wire logic [NUM_EP-1:0] ep_toggle_out,
  input wire logic [NUM_EP-1:0] ep_halt_out,
  input wire logic              rwake_en_out,
  input wire logic              wakeup_out,
  input wire logic              port_reset_out,
  input wire logic              port_enabled_out,
  input wire logic              port_change_out
);
  logic [31:0] quiet_r;
  // cycles since the last observed bus activity
  always_ff @(posedge clk_in) begin
    if (rst_in || bus_reset_in || bus_activity_in) begin
      quiet_r <= 32'h0;
    end else if (quiet_r != 32'hffff_ffff) begin
      quiet_r <= quiet_r + 32'h1;
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  a_cfg_cause: assert property (dev_state_out == 2'h2 && $past(dev_state_out) != 2'h2 |-> $past(req_valid_in, 2)
    && $past(req_kind_in, 2) == usm_pkg::USM_REQ_SET_CFG && $past(req_value_in, 2) != 8'h00) else $error("configured without cause");
  a_cfg_defaults: assert property ($changed(config_out) |-> ep_toggle_out == '0 && ep_halt_out == '0)
    else $error("endpoints not defaulted");
  a_idle_suspend: assert property (quiet_r > IDLE_CYC + 2 |-> suspended_out) else $error("idle bus not suspended");
  a_susp_keeps: assert property (suspended_out && !bus_reset_in && !req_valid_in |=> $stable(dev_addr_out)
    && $stable(config_out) && $stable(dev_state_out)) else $error("state lost in suspend");
  a_port_suspend: assert property ($rose(port_disabled_in) |-> ##[1:5] suspended_out) else $error("no selective suspend");
  a_activity_wake: assert property (suspended_out && bus_activity_in && !port_disabled_in && !bus_reset_in
    |=> !suspended_out) else $error("activity did not resume");
  a_wake_gated: assert property (wakeup_out |-> rwake_en_out) else $error("wakeup while disabled");
  a_bus_reset: assert property (bus_reset_in |=> dev_state_out == 2'h0 && dev_addr_out == 7'h00
    && config_out == 8'h00 && !rwake_en_out && !suspended_out) else $error("bus reset incomplete");
  a_req_busy: assert property (req_valid_in && !busy_out |=> busy_out ##1 !busy_out) else $error("busy window wrong");
  a_port_done: assert property ($fell(port_reset_out) |-> port_enabled_out && port_change_out)
    else $error("port reset end not flagged");
endmodule

bind usm_top usm_top_assertions #(.NUM_EP(NUM_EP), .IDLE_CYC(IDLE_CYC)) u_usm_chk (.*);

//--- test/testbench.sv
// self-checking bench for the usb device state manager
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [3:0] kind;
    logic [7:0] value;
    logic [7:0] index;
    logic [1:0] state;
    logic       stall;
  } usm_row_s;
  localparam int unsigned IDLE = 20;
  localparam int unsigned PRST = 10;
  localparam usm_row_s ROWS [17] = '{
    {usm_pkg::USM_REQ_GET_INTF, 8'h00, 8'h00, 2'h0, 1'b1}, {usm_pkg::USM_REQ_SET_CFG, 8'h01, 8'h00, 2'h0, 1'b1},
    {usm_pkg::USM_REQ_SET_ADDR, 8'h80, 8'h00, 2'h0, 1'b1}, {usm_pkg::USM_REQ_SET_ADDR, 8'h05, 8'h00, 2'h1, 1'b0},
    {usm_pkg::USM_REQ_SET_CFG, 8'h03, 8'h00, 2'h1, 1'b1}, {usm_pkg::USM_REQ_SET_CFG, 8'h02, 8'h00, 2'h2, 1'b0},
    {usm_pkg::USM_REQ_SET_INTF, 8'h01, 8'h00, 2'h2, 1'b0}, {usm_pkg::USM_REQ_GET_INTF, 8'h00, 8'h00, 2'h2, 1'b0},
    {usm_pkg::USM_REQ_SET_INTF, 8'h02, 8'h00, 2'h2, 1'b1}, {usm_pkg::USM_REQ_SET_INTF, 8'h00, 8'h04, 2'h2, 1'b1},
    {usm_pkg::USM_REQ_SET_HALT, 8'h00, 8'h01, 2'h2, 1'b0}, {usm_pkg::USM_REQ_CLR_HALT, 8'h00, 8'h09, 2'h2, 1'b1},
    {usm_pkg::USM_REQ_CLR_HALT, 8'h00, 8'h01, 2'h2, 1'b0}, {usm_pkg::USM_REQ_SET_ADDR, 8'h06, 8'h00, 2'h2, 1'b1},
    {usm_pkg::USM_REQ_CLR_RWAKE, 8'h00, 8'h00, 2'h2, 1'b0}, {4'hf, 8'h00, 8'h00, 2'h2, 1'b1},
    {usm_pkg::USM_REQ_SET_RWAKE, 8'h00, 8'h00, 2'h2, 1'b0}};
  logic        clk_in = 1'b0, rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, saw_wake = 1'b0;
  logic        bus_reset = 1'b0, tb_act = 1'b0, port_dis = 1'b0, ok, er;
  logic        pready, pslverr, busy, stall, susp, rwake, wake, prst, pen, pchg, rv, sd, hact;
  logic [31:0] pwdata = 32'h0, rd, prdata, alt_set;
  logic [7:0]  paddr = 8'h00, flip = 8'h00, alt_rep, cfg, tog, halt, rvl, ri;
  logic [6:0]  addr;
  logic [3:0]  rk;
  logic [1:0]  state;
  int          mismatches = 0, comparisons = 0, n;
  usm_top #(.IDLE_CYC(IDLE), .PRST_CYC(PRST)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
    .bus_reset_in(bus_reset), .bus_activity_in(hact | tb_act), .port_disabled_in(port_dis),
    .req_valid_in(rv), .req_kind_in(rk), .req_value_in(rvl), .req_index_in(ri), .status_done_in(sd),
    .toggle_flip_in(flip), .busy_out(busy), .stall_out(stall), .alt_report_out(alt_rep),
    .dev_state_out(state), .suspended_out(susp), .dev_addr_out(addr), .config_out(cfg),
    .alt_setting_out(alt_set), .ep_toggle_out(tog), .ep_halt_out(halt), .rwake_en_out(rwake),
    .wakeup_out(wake), .port_reset_out(prst), .port_enabled_out(pen), .port_change_out(pchg));
  usm_host_model host (.clk_in(clk_in), .busy_in(busy), .req_valid_out(rv), .req_kind_out(rk),
    .req_value_out(rvl), .req_index_out(ri), .status_done_out(sd), .activity_out(hact));
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (wake === 1'b1) begin
      saw_wake <= 1'b1;
    end
  end
  task automatic tally_and_finish();
    if (mismatches == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic give_up();
    mismatches++;
    $display("[ERR] %0t wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge clk_in);
      k++;
    end
    if (k >= 20) give_up();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse_act();
    @(posedge clk_in);
    tb_act <= 1'b1;
    @(posedge clk_in);
    tb_act <= 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    bus_reset <= 1'b1;
    @(posedge clk_in);
    bus_reset <= 1'b0;
    apb(1'b1, usm_pkg::OFS_CFG, 32'h0000_0202);
    foreach (ROWS[k]) begin
      host.request(ROWS[k].kind, ROWS[k].value, ROWS[k].index, ok);
      if (ok !== 1'b1) give_up();
      repeat (2) @(negedge clk_in);
      chk(stall, ROWS[k].stall);
      chk(state, ROWS[k].state);
    end
    chk(addr, 7'h05);
    chk(alt_rep, 8'h01);
    chk(rwake, 1'b1);
    @(posedge clk_in);
    flip <= 8'h05;
    @(posedge clk_in);
    flip <= 8'h00;
    @(negedge clk_in);
    chk(tog, 8'h05);
    host.request(usm_pkg::USM_REQ_SET_HALT, 8'h00, 8'h03, ok);
    if (ok !== 1'b1) give_up();
    @(negedge clk_in);
    chk(halt, 8'h08);
    host.request(usm_pkg::USM_REQ_SET_CFG, 8'h02, 8'h00, ok);
    if (ok !== 1'b1) give_up();
    @(negedge clk_in);
    chk(tog, 8'h00);
    chk(halt, 8'h00);
    chk(alt_set, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, usm_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h0002_050a);
    pulse_act();
    repeat (IDLE - 4) @(negedge clk_in);
    chk(susp, 1'b0);
    repeat (8) @(negedge clk_in);
    chk(susp, 1'b1);
    chk({state, 1'b0, addr}, {2'h2, 8'h05});
    apb(1'b1, usm_pkg::OFS_CTRL, 32'h2);
    repeat (2) @(negedge clk_in);
    chk(saw_wake, 1'b1);
    pulse_act();
    @(negedge clk_in);
    chk(susp, 1'b0);
    @(posedge clk_in);
    port_dis <= 1'b1;
    repeat (6) @(negedge clk_in);
    chk(susp, 1'b1);
    @(posedge clk_in);
    port_dis <= 1'b0;
    repeat (6) @(posedge clk_in);
    pulse_act();
    @(negedge clk_in);
    chk(susp, 1'b0);
    apb(1'b1, usm_pkg::OFS_CTRL, 32'h1);
    repeat (2) @(negedge clk_in);
    chk({prst, pen}, 2'b10);
    n = 0;
    while (prst === 1'b1 && n < 100) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 100) give_up();
    chk(n > PRST - 4 && n < PRST + 2, 1'b1);
    chk({pen, pchg}, 2'b11);
    apb(1'b0, usm_pkg::OFS_PCHG, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, usm_pkg::OFS_PCHG, 32'h1);
    apb(1'b0, usm_pkg::OFS_PCHG, 32'h0);
    chk(rd, 32'h0);
    @(posedge clk_in);
    bus_reset <= 1'b1;
    repeat (2) @(posedge clk_in);
    bus_reset <= 1'b0;
    @(negedge clk_in);
    chk({state, addr, cfg, rwake, susp}, 19'h0);
    repeat (IDLE + 6) @(negedge clk_in);
    chk({state, susp}, 3'b001);
    apb(1'b1, usm_pkg::OFS_CTRL, 32'h2);
    @(negedge clk_in);
    chk(wake, 1'b0);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    chk({susp, pen, pchg, stall}, 4'h0);
    apb(1'b0, usm_pkg::OFS_CFG, 32'h0);
    chk(rd, 32'h0000_0101);
    apb(1'b0, usm_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    tally_and_finish();
  end
endmodule
